// ---- core/seac_defs.svh ----
// register offsets, field positions, reset values and timing counts
`ifndef SEAC_DEFS_SVH
`define SEAC_DEFS_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define SEAC_OFS_MODE      8'hf1
`define SEAC_OFS_PTR       8'hf2
`define SEAC_OFS_WPORT     8'hf3
`define SEAC_OFS_WSTAT     8'hf4
`define SEAC_OFS_RPORT     8'hf5
`define SEAC_OFS_RSTAT     8'hf6
`define SEAC_OFS_IRQ_STS   8'hf8
`define SEAC_OFS_IRQ_MSK   8'hf9

// ****************************************************************
// field positions and encodings
// ****************************************************************
`define SEAC_MODE_SIZE_BIT 4
`define SEAC_WST_DIR_BIT   7
`define SEAC_EV_RDY        0
`define SEAC_EV_WDONE      1
`define SEAC_EV_DENY       2
`define SEAC_WST_IDLE      2'h3
`define SEAC_WST_HALF      2'h2
`define SEAC_WST_BUSY      2'h0
`define SEAC_OP_READ       2'h2
`define SEAC_OP_WRITE      2'h1
`define SEAC_OP_EWEN       2'h0
`define SEAC_EWEN_ADR_L    8'hc0
`define SEAC_EWEN_ADR_S    6'h30

// ****************************************************************
// reset values
// ****************************************************************
`define SEAC_RST_LOCK      4'h0
`define SEAC_RST_PTR       8'h00
`define SEAC_RST_WST       2'h3
`define SEAC_RST_IRQ       3'h0

// ****************************************************************
// frame lengths and timing
// ****************************************************************
`define SEAC_FRAME_L       5'h1b
`define SEAC_FRAME_S       5'h19
`define SEAC_EWEN_L        5'h0b
`define SEAC_EWEN_S        5'h09
`define SEAC_DATA_BITS     5'h10
`define SEAC_CLK_PS        4000
`define SEAC_SK_HALF_NS    500
`define SEAC_SK_HALF_CYC   \
  ((`SEAC_SK_HALF_NS * 1000 + `SEAC_CLK_PS - 1) / `SEAC_CLK_PS)

`endif

// ---- core/seac_pkg.sv ----
// types shared by the serial memory access block
package seac_pkg;

  // ****************************************************************
  // serial engine state and job
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_LOW  = 3'b001,
    ST_HIGH = 3'b010,
    ST_GAP  = 3'b011,
    ST_POLL = 3'b100
  } seac_state_t;

  typedef enum logic [2:0] {
    JB_NONE  = 3'b000,
    JB_READ  = 3'b001,
    JB_EWEN  = 3'b010,
    JB_WRITE = 3'b011,
    JB_FIN   = 3'b100
  } seac_job_t;

  // ****************************************************************
  // register bus request
  // ****************************************************************
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } seac_bus_t;

endpackage : seac_pkg

// ---- core/seac_sync.sv ----
// two flip-flop synchroniser for levels from outside the clock domain
`timescale 1ns/1ps
module seac_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // first stage feeds only the second stage
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= d_in;
      sync_q <= meta_q;
    end
  end

  assign q_out = sync_q;
endmodule : seac_sync

// ---- core/seac_top.sv ----
// serial memory access controller: host registers and serial engine
//
// Our own choice: strobed register access.
`timescale 1ns/1ps
`include "seac_defs.svh"
module seac_top (
  input  wire logic              core_clk_in,
  input  wire logic              rst_in,
  input  wire logic              cfg_mode_in,
  input  wire seac_pkg::seac_bus_t bus_in,
  output logic [7:0]             rdata_out,
  output logic                   irq_out,
  input  wire logic              mem_serial_in_pin_in,
  output logic                   mem_serial_out_pin_out,
  output logic                   mem_serial_clock_pin_out,
  output logic                   mem_select_pin_out
);
  import seac_pkg::*;

  localparam logic [7:0] HALF_M1 = 8'(`SEAC_SK_HALF_CYC - 1);

  // ****************************************************************
  // signals
  // ****************************************************************
  logic        din_s;
  logic [3:0]  lock_q, lock_d;
  logic        size_q, size_d;
  logic [7:0]  ptr_q, ptr_d;
  logic        dir_q, dir_d;
  logic [1:0]  wst_q, wst_d;
  logic [15:0] wword_q, wword_d;
  logic [15:0] rword_q, rword_d;
  logic        rhi_q, rhi_d;
  logic        rvalid_q, rvalid_d;
  logic        pf_q, pf_d;
  logic        wr_q, wr_d;
  logic [2:0]  ists_q, ists_d;
  logic [2:0]  imsk_q, imsk_d;
  logic [7:0]  rdata_q, rdata_d;
  logic        irq_q, irq_d;
  logic [2:0]  ev;
  logic        wr_acc, rd_acc, lock_hit;
  seac_state_t st_q, st_d;
  seac_job_t   job_q, job_d;
  logic [7:0]  div_q, div_d;
  logic [4:0]  cnt_q, cnt_d;
  logic [26:0] sh_q, sh_d;
  logic [15:0] cap_q, cap_d;
  logic [7:0]  eaddr_q, eaddr_d;
  logic        cs_q, cs_d, sk_q, sk_d, do_q, do_d;
  logic        take_rd, take_wr, fin_rd, fin_wr;

  // serial input from the memory crosses into the core clock
  seac_sync #(.W(1)) u_din_sync (
    .clk_in (core_clk_in),
    .rst_in (rst_in),
    .d_in   (mem_serial_in_pin_in),
    .q_out  (din_s)
  );

  // ****************************************************************
  // host register file
  // ****************************************************************

  // lock check of the current pointer against the four blocks
  assign lock_hit = (ptr_q[7:6] == 2'h0) && lock_q[ptr_q[5:4]];

  // next state of the host registers
  always_comb begin
    lock_d   = lock_q;
    size_d   = size_q;
    ptr_d    = ptr_q;
    dir_d    = dir_q;
    wst_d    = wst_q;
    wword_d  = wword_q;
    rword_d  = rword_q;
    rhi_d    = rhi_q;
    rvalid_d = rvalid_q;
    pf_d     = pf_q;
    wr_d     = wr_q;
    imsk_d   = imsk_q;
    rdata_d  = 8'h00;
    ev       = 3'h0;
    wr_acc   = bus_in.wr && cfg_mode_in;
    rd_acc   = bus_in.rd && cfg_mode_in;
    if ((bus_in.wr || bus_in.rd) && !cfg_mode_in) begin
      ev[`SEAC_EV_DENY] = 1'b1;
    end
    if (take_rd) begin
      pf_d = 1'b0;
    end
    if (take_wr) begin
      wr_d = 1'b0;
    end
    // a prefetch into a locked block is dropped
    if (pf_q && lock_hit && st_q == ST_IDLE && !wr_q) begin
      pf_d              = 1'b0;
      ev[`SEAC_EV_DENY] = 1'b1;
    end
    // fetched word lands unless the pointer moved meanwhile in read direction
    if (fin_rd && !pf_q) begin
      rword_d          = cap_q;
      rvalid_d         = 1'b1;
      rhi_d            = 1'b0;
      ev[`SEAC_EV_RDY] = 1'b1;
    end
    // write done: ready again and step the pointer
    if (fin_wr) begin
      wst_d              = `SEAC_WST_IDLE;
      ptr_d              = ptr_q + 8'h01;
      ev[`SEAC_EV_WDONE] = 1'b1;
      pf_d               = !dir_q;
    end
    if (wr_acc) begin
      case (bus_in.addr)
        `SEAC_OFS_MODE: begin
          lock_d = lock_q | bus_in.wdata[3:0];
          size_d = bus_in.wdata[`SEAC_MODE_SIZE_BIT];
        end
        `SEAC_OFS_PTR: begin
          ptr_d    = bus_in.wdata;
          rvalid_d = 1'b0;
          rhi_d    = 1'b0;
          pf_d     = !dir_q;
        end
        `SEAC_OFS_WPORT: begin
          if (wst_q == `SEAC_WST_IDLE) begin
            wword_d[7:0] = bus_in.wdata;
            wst_d        = `SEAC_WST_HALF;
          end else if (wst_q == `SEAC_WST_HALF) begin
            wword_d[15:8] = bus_in.wdata;
            if (lock_hit) begin
              wst_d             = `SEAC_WST_IDLE;
              ptr_d             = ptr_q + 8'h01;
              ev[`SEAC_EV_DENY] = 1'b1;
            end else begin
              wst_d = `SEAC_WST_BUSY;
              wr_d  = 1'b1;
            end
          end
        end
        `SEAC_OFS_WSTAT: begin
          dir_d = bus_in.wdata[`SEAC_WST_DIR_BIT];
        end
        `SEAC_OFS_IRQ_MSK: begin
          imsk_d = bus_in.wdata[2:0];
        end
        default: begin
        end
      endcase
    end
    if (rd_acc) begin
      case (bus_in.addr)
        `SEAC_OFS_MODE: begin
          rdata_d = {3'h0, size_q, lock_q};
        end
        `SEAC_OFS_PTR: begin
          rdata_d = ptr_q;
        end
        `SEAC_OFS_WSTAT: begin
          rdata_d = {dir_q, 5'h00, wst_q};
        end
        `SEAC_OFS_RPORT: begin
          rdata_d = rhi_q ? rword_q[15:8] : rword_q[7:0];
          if (rvalid_q && !rhi_q) begin
            rhi_d = 1'b1;
          end else if (rvalid_q) begin
            rvalid_d = 1'b0;
            rhi_d    = 1'b0;
            ptr_d    = ptr_q + 8'h01;
            pf_d     = !dir_q;
          end
        end
        `SEAC_OFS_RSTAT: begin
          rdata_d = {7'h00, rvalid_q};
        end
        `SEAC_OFS_IRQ_STS: begin
          rdata_d = {5'h00, ists_q};
        end
        `SEAC_OFS_IRQ_MSK: begin
          rdata_d = {5'h00, imsk_q};
        end
        default: begin
          rdata_d = 8'h00;
        end
      endcase
    end
    // sticky events: a new event wins over a clearing write
    ists_d = ists_q;
    if (wr_acc && bus_in.addr == `SEAC_OFS_IRQ_STS) begin
      ists_d = ists_q & ~bus_in.wdata[2:0];
    end
    ists_d = ists_d | ev;
    irq_d  = |(ists_d & imsk_d);
  end

  // host register storage
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      lock_q   <= `SEAC_RST_LOCK;
      size_q   <= 1'b0;
      ptr_q    <= `SEAC_RST_PTR;
      dir_q    <= 1'b0;
      wst_q    <= `SEAC_RST_WST;
      wword_q  <= 16'h0000;
      rword_q  <= 16'h0000;
      rhi_q    <= 1'b0;
      rvalid_q <= 1'b0;
      pf_q     <= 1'b0;
      wr_q     <= 1'b0;
      ists_q   <= `SEAC_RST_IRQ;
      imsk_q   <= `SEAC_RST_IRQ;
      rdata_q  <= 8'h00;
      irq_q    <= 1'b0;
    end else begin
      lock_q   <= lock_d;
      size_q   <= size_d;
      ptr_q    <= ptr_d;
      dir_q    <= dir_d;
      wst_q    <= wst_d;
      wword_q  <= wword_d;
      rword_q  <= rword_d;
      rhi_q    <= rhi_d;
      rvalid_q <= rvalid_d;
      pf_q     <= pf_d;
      wr_q     <= wr_d;
      ists_q   <= ists_d;
      imsk_q   <= imsk_d;
      rdata_q  <= rdata_d;
      irq_q    <= irq_d;
    end
  end

  assign rdata_out = rdata_q;
  assign irq_out   = irq_q;

  // ****************************************************************
  // serial engine
  // ****************************************************************

  // jobs start only from idle; a pending write goes first
  assign take_wr = (st_q == ST_IDLE) && wr_q;
  assign take_rd = (st_q == ST_IDLE) && !wr_q && pf_q && !lock_hit;

  // next state of the serial engine
  always_comb begin
    st_d    = st_q;
    job_d   = job_q;
    div_d   = div_q;
    cnt_d   = cnt_q;
    sh_d    = sh_q;
    cap_d   = cap_q;
    eaddr_d = eaddr_q;
    cs_d    = cs_q;
    sk_d    = sk_q;
    do_d    = do_q;
    fin_rd  = 1'b0;
    fin_wr  = 1'b0;
    case (st_q)
      ST_IDLE: begin
        cs_d    = 1'b0;
        sk_d    = 1'b0;
        do_d    = 1'b0;
        eaddr_d = ptr_q;
        div_d   = HALF_M1;
        if (take_wr) begin
          // write enable frame precedes each write
          job_d = JB_EWEN;
          sh_d  = size_q ?
            {1'b1, `SEAC_OP_EWEN, `SEAC_EWEN_ADR_L, 16'h0000} :
            {1'b1, `SEAC_OP_EWEN, `SEAC_EWEN_ADR_S, 18'h00000};
          cnt_d = size_q ? `SEAC_EWEN_L : `SEAC_EWEN_S;
          cs_d  = 1'b1;
          do_d  = 1'b1;
          st_d  = ST_LOW;
        end else if (take_rd) begin
          job_d = JB_READ;
          sh_d  = size_q ?
            {1'b1, `SEAC_OP_READ, ptr_q, 16'h0000} :
            {1'b1, `SEAC_OP_READ, ptr_q[5:0], 18'h00000};
          cnt_d = size_q ? `SEAC_FRAME_L : `SEAC_FRAME_S;
          cs_d  = 1'b1;
          do_d  = 1'b1;
          st_d  = ST_LOW;
        end
      end
      ST_LOW: begin
        div_d = div_q - 8'h01;
        if (div_q == 8'h00) begin
          sk_d  = 1'b1;
          div_d = HALF_M1;
          st_d  = ST_HIGH;
        end
      end
      ST_HIGH: begin
        div_d = div_q - 8'h01;
        if (div_q == 8'h00) begin
          sk_d  = 1'b0;
          div_d = HALF_M1;
          if (job_q == JB_READ && cnt_q <= `SEAC_DATA_BITS) begin
            cap_d = {cap_q[14:0], din_s};
          end
          sh_d  = {sh_q[25:0], 1'b0};
          do_d  = sh_q[25];
          cnt_d = cnt_q - 5'h01;
          if (cnt_q == 5'h01) begin
            cs_d = 1'b0;
            do_d = 1'b0;
            st_d = ST_GAP;
          end else begin
            st_d = ST_LOW;
          end
        end
      end
      ST_GAP: begin
        div_d = div_q - 8'h01;
        if (div_q == 8'h00) begin
          div_d = HALF_M1;
          case (job_q)
            JB_EWEN: begin
              job_d = JB_WRITE;
              sh_d  = size_q ?
                {1'b1, `SEAC_OP_WRITE, eaddr_q, wword_q} :
                {1'b1, `SEAC_OP_WRITE, eaddr_q[5:0], wword_q, 2'h0};
              cnt_d = size_q ? `SEAC_FRAME_L : `SEAC_FRAME_S;
              cs_d  = 1'b1;
              do_d  = 1'b1;
              st_d  = ST_LOW;
            end
            JB_WRITE: begin
              cs_d = 1'b1;
              st_d = ST_POLL;
            end
            JB_READ: begin
              fin_rd = 1'b1;
              job_d  = JB_NONE;
              st_d   = ST_IDLE;
            end
            default: begin
              fin_wr = 1'b1;
              job_d  = JB_NONE;
              st_d   = ST_IDLE;
            end
          endcase
        end
      end
      ST_POLL: begin
        // the released output is only trusted a half period after select;
        // then the memory holds it low until the write has finished
        if (div_q != 8'h00) begin
          div_d = div_q - 8'h01;
        end else if (din_s) begin
          cs_d  = 1'b0;
          job_d = JB_FIN;
          div_d = HALF_M1;
          st_d  = ST_GAP;
        end
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
  end

  // serial engine storage; pins come straight from these flops
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      st_q    <= ST_IDLE;
      job_q   <= JB_NONE;
      div_q   <= 8'h00;
      cnt_q   <= 5'h00;
      sh_q    <= 27'h0000000;
      cap_q   <= 16'h0000;
      eaddr_q <= 8'h00;
      cs_q    <= 1'b0;
      sk_q    <= 1'b0;
      do_q    <= 1'b0;
    end else begin
      st_q    <= st_d;
      job_q   <= job_d;
      div_q   <= div_d;
      cnt_q   <= cnt_d;
      sh_q    <= sh_d;
      cap_q   <= cap_d;
      eaddr_q <= eaddr_d;
      cs_q    <= cs_d;
      sk_q    <= sk_d;
      do_q    <= do_d;
    end
  end

  assign mem_serial_out_pin_out   = do_q;
  assign mem_serial_clock_pin_out = sk_q;
  assign mem_select_pin_out       = cs_q;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);

  sequence s_hi_read;
    rd_acc && bus_in.addr == `SEAC_OFS_RPORT && rvalid_q && rhi_q;
  endsequence

  sequence s_second_byte;
    wr_acc && bus_in.addr == `SEAC_OFS_WPORT &&
      wst_q == `SEAC_WST_HALF && !lock_hit;
  endsequence

  lock_sticky_a: assert property (
    (lock_q & $past(lock_q)) == $past(lock_q))
    else $error("lock bit cleared");

  cfg_refuse_a: assert property (
    bus_in.wr && !cfg_mode_in |=> $stable(lock_q) && $stable(dir_q)
      && $stable(imsk_q) && $stable(size_q))
    else $error("register changed outside configuration mode");

  first_byte_a: assert property (
    wr_acc && bus_in.addr == `SEAC_OFS_WPORT &&
      wst_q == `SEAC_WST_IDLE |=> wst_q == `SEAC_WST_HALF)
    else $error("first byte did not clear status bit 0");

  second_byte_a: assert property (
    s_second_byte |=> wst_q == `SEAC_WST_BUSY && wr_q)
    else $error("second byte did not start a write");

  busy_hold_a: assert property (
    wst_q == `SEAC_WST_BUSY && !fin_wr |=> wst_q == `SEAC_WST_BUSY)
    else $error("write status left busy early");

  poll_ready_a: assert property (
    st_q == ST_POLL && st_d == ST_GAP |-> din_s ##1 !cs_q)
    else $error("poll ended without ready");

  high_read_a: assert property (
    s_hi_read |=> !rvalid_q && ptr_q == $past(ptr_q) + 8'h01
      && pf_q == !dir_q)
    else $error("high byte read did not advance");

  low_read_a: assert property (
    rd_acc && bus_in.addr == `SEAC_OFS_RPORT && !rhi_q
      |=> rdata_out == $past(rword_q[7:0]))
    else $error("read port low byte wrong");

  no_prefetch_a: assert property (
    wr_acc && bus_in.addr == `SEAC_OFS_PTR && dir_q && !pf_q |=> !pf_q)
    else $error("prefetch in write direction");

  lock_deny_a: assert property (
    take_rd || take_wr |-> !lock_hit || take_wr && !wr_q)
    else $error("serial access to a locked block");

  clock_frame_a: assert property (
    $rose(mem_serial_clock_pin_out) |-> mem_select_pin_out
      ##1 mem_serial_clock_pin_out [*8])
    else $error("serial clock high outside frame or too short");

endmodule : seac_top

// ---- dv/seac_mem_model.sv ----
// behavioural serial memory of sixteen-bit words, far side of the link
`timescale 1ns/1ps
module seac_mem_model (
  input  wire logic clk_in,
  input  wire logic size_in,
  input  wire logic sk_in,
  input  wire logic cs_in,
  input  wire logic di_in,
  output logic      do_out
);
  logic [15:0] mem [256];
  logic [31:0] sr;
  logic [7:0]  a;
  logic [5:0]  n, hdr;
  logic [1:0]  op;
  logic [9:0]  busy;
  logic        sk_q, we;

  // ************************************************************
  // contents and framing
  // ************************************************************
  // preset words follow a formula that the bench repeats
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 16'h5a3c ^ 16'(i * 257);
    {sr, a, n, op, busy, sk_q, we, do_out} = '0;
  end
  assign hdr = size_in ? 6'd11 : 6'd9;

  // pins taken as they come, no inversion anywhere
  always @(posedge clk_in) begin
    sk_q <= sk_in;
    if (busy != 0) busy <= busy - 10'd1;
    if (!cs_in) begin
      n <= 6'd0;
      do_out <= ~do_out; // released line keeps changing
    end else begin
      if (sk_in && !sk_q) begin
        n <= n + 6'd1;
        sr <= {sr[30:0], di_in};
        if (n == 6'd2) op <= {sr[0], di_in};
        if (n == hdr - 6'd1) begin
          a <= size_in ? {sr[6:0], di_in} : {2'b0, sr[4:0], di_in};
          if (op == 2'b00 && (size_in ? sr[6:5] : sr[4:3]) == 2'b11)
            we <= 1'b1;
        end
        // a write needs the enable first and then keeps us busy
        if (n == hdr + 6'd15 && op == 2'b01 && we) begin
          mem[a] <= {sr[14:0], di_in};
          busy <= 10'd900;
        end
      end
      if (n == 6'd0) do_out <= (busy == 0);
      else if (op == 2'b10 && n > hdr && n <= hdr + 6'd16)
        do_out <= mem[a][4'(hdr + 6'd16 - n)];
      else do_out <= ~do_out;
    end
  end
endmodule : seac_mem_model

// ---- dv/tb_seac_top.sv ----
// self-checking bench of the serial memory access controller
`timescale 1ns/1ps
`include "seac_defs.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
  miscompares++; $display("wrong value at %0t: %h not %h", $time, g, e); \
  end end
module tb_seac_top;
  import seac_pkg::*;
  localparam logic [7:0] a_md = `SEAC_OFS_MODE;
  localparam logic [7:0] a_pt = `SEAC_OFS_PTR;
  localparam logic [7:0] a_wp = `SEAC_OFS_WPORT;
  localparam logic [7:0] a_ws = `SEAC_OFS_WSTAT;
  localparam logic [7:0] a_rp = `SEAC_OFS_RPORT;
  localparam logic [7:0] a_rs = `SEAC_OFS_RSTAT;
  localparam logic [7:0] a_is = `SEAC_OFS_IRQ_STS;
  localparam logic [7:0] a_im = `SEAC_OFS_IRQ_MSK;
  logic        clk, rst, cfg, irq, din, dout, sck, cs, rd_seen, size_q;
  seac_bus_t   bus;
  logic [7:0]  rdata, v, p;
  logic [15:0] wd;
  logic [15:0] img [256];
  logic [8:0]  note;
  logic [8:0]  notes [$];
  int          miscompares, samples_checked, cycles;

  seac_top u_seac_top (.core_clk_in(clk), .rst_in(rst), .cfg_mode_in(cfg),
    .bus_in(bus), .rdata_out(rdata), .irq_out(irq),
    .mem_serial_in_pin_in(din), .mem_serial_out_pin_out(dout),
    .mem_serial_clock_pin_out(sck), .mem_select_pin_out(cs));
  seac_mem_model u_seac_mem_model (.clk_in(clk), .size_in(size_q),
    .sk_in(sck), .cs_in(cs), .di_in(dout), .do_out(din));

  // ************************************************************
  // clock, timeout, verdict
  // ************************************************************
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic give_verdict();
    $display("checked %0d wrong %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : give_verdict
  // a hang is cut short well above the expected run length
  always @(posedge clk) begin
    cycles++;
    if (cycles == 95000) begin
      miscompares++;
      give_verdict();
    end
  end

  // ************************************************************
  // register bus tasks and read monitor
  // ************************************************************
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) bus <= '{1'b1, 1'b0, a, d};
    @(posedge clk) bus <= '0;
  endtask : wr
  // each read leaves a note: check flag and expected byte
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic c);
    @(posedge clk) bus <= '{1'b0, 1'b1, a, 8'h00};
    notes.push_back({c, e});
    @(posedge clk) bus <= '0;
    @(posedge clk) v = rdata;
  endtask : rd
  task automatic poll(input logic [7:0] a, input logic [7:0] m);
    for (int i = 0; i < 30000; i++) begin
      rd(a, 8'h00, 1'b0);
      if ((v & m) === m) return;
    end
    // a poll that never sees its bits counts as a failure
    miscompares++;
    $display("wrong value at %0t: poll ran out", $time);
  endtask : poll
  // read data stand only in the cycle after the strobe
  always @(posedge clk) begin
    rd_seen <= bus.rd;
    if (rd_seen) begin
      note = notes.pop_front();
      if (note[8]) `CHK(rdata, note[7:0])
    end
  end

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    {bus, size_q} = '0;
    {rst, cfg} = 2'b11;
    void'($urandom(68991));
    for (int i = 0; i < 256; i++) img[i] = 16'h5a3c ^ 16'(i * 257);
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rd(a_md, 8'h00, 1'b1);
    rd(a_pt, 8'h00, 1'b1);
    rd(a_ws, 8'h03, 1'b1);
    rd(a_rs, 8'h00, 1'b1);
    rd(8'hf7, 8'h00, 1'b1);
    // refused access outside configuration mode
    wr(a_im, 8'h04);
    cfg <= 1'b0;
    wr(a_pt, 8'h55);
    rd(a_pt, 8'h00, 1'b1);
    cfg <= 1'b1;
    rd(a_pt, 8'h00, 1'b1);
    `CHK(irq, 1'b1)
    wr(a_is, 8'h07);
    wr(a_im, 8'h01);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b0)
    $display("test reset and refusal done");
    // word write then read back, large part first
    for (int s = 1; s >= 0; s--) begin
      wr(a_is, 8'h07);
      p = 8'h20 + 8'($urandom_range(14));
      wd = 16'($urandom);
      size_q <= s[0];
      wr(a_md, {3'h0, s[0], 4'h0});
      rd(a_md, {3'h0, s[0], 4'h0}, 1'b1);
      wr(a_ws, 8'h80);
      wr(a_pt, p);
      wr(a_wp, wd[7:0]);
      rd(a_ws, 8'h82, 1'b1);
      wr(a_wp, wd[15:8]);
      rd(a_ws, 8'h80, 1'b1);
      poll(a_ws, 8'h03);
      rd(a_is, 8'h02, 1'b1);
      rd(a_pt, p + 8'h01, 1'b1);
      rd(a_rs, 8'h00, 1'b1);
      img[p] = wd;
      wr(a_ws, 8'h00);
      wr(a_pt, p);
      poll(a_rs, 8'h01);
      `CHK(irq, 1'b1)
      wr(a_is, 8'h01);
      repeat (2) @(posedge clk);
      `CHK(irq, 1'b0)
      rd(a_rp, img[p][7:0], 1'b1);
      rd(a_rs, 8'h01, 1'b1);
      rd(a_rp, img[p][15:8], 1'b1);
      rd(a_rs, 8'h00, 1'b1);
      rd(a_pt, p + 8'h01, 1'b1);
      poll(a_rs, 8'h01);
      rd(a_rp, img[p + 8'h01][7:0], 1'b1);
      rd(a_rp, img[p + 8'h01][15:8], 1'b1);
      poll(a_rs, 8'h01);
      $display("test size %0d done", s);
    end
    // lock bits only gather, and guard their blocks
    wr(a_is, 8'h07);
    size_q <= 1'b1;
    wr(a_md, 8'h11);
    wr(a_md, 8'h12);
    rd(a_md, 8'h13, 1'b1);
    wr(a_md, 8'h10);
    rd(a_md, 8'h13, 1'b1);
    wr(a_ws, 8'h00);
    wr(a_pt, 8'h05);
    repeat (300) @(posedge clk);
    rd(a_rs, 8'h00, 1'b1);
    rd(a_is, 8'h04, 1'b1);
    wr(a_ws, 8'h80);
    wr(a_pt, 8'h12);
    wr(a_wp, 8'haa);
    wr(a_wp, 8'h55);
    repeat (10) @(posedge clk);
    `CHK(cs, 1'b0)
    rd(a_ws, 8'h83, 1'b1);
    rd(a_pt, 8'h13, 1'b1);
    $display("test locks done");
    give_verdict();
  end
endmodule : tb_seac_top
